// ### flash_ctl.sv
`default_nettype none
module flash_ctl #(
  parameter int unsigned LED_DLY = flash_ctl_pkg::LED_DLY_CYC,
  parameter int unsigned VOUT_DLY = flash_ctl_pkg::VOUT_DLY_CYC,
  parameter int unsigned TOUT_STEP = flash_ctl_pkg::TOUT_STEP_CYC,
  parameter int unsigned RAMP_STEP = flash_ctl_pkg::RAMP_STEP_CYC,
  // silicon revision code, arbitrary value
  parameter logic [2:0] SILICON_REV = 3'h1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire flash_ctl_pkg::sense_t i_sense,
  output flash_ctl_pkg::drive_t o_drive
);
  import flash_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  sense_t s1_ff;
  sense_t s2_ff;
  logic strobe_prev_ff;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      strobe_prev_ff <= 1'b0;
    end else begin
      s1_ff <= i_sense;
      s2_ff <= s1_ff;
      strobe_prev_ff <= s2_ff.strobe;
    end
  end
  wire strobe_rise = s2_ff.strobe & ~strobe_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [7:0] regs_ff [0:9];
  logic [7:0] en_ff;
  logic [7:0] flags_ff;
  logic lock_ff;
  wire [3:0] idx = i_wb_adr[5:2];
  wire mapped = (i_wb_adr[7:6] == 2'h0) && (idx <= REG_FLAGS);
  wire req = i_wb_cyc & i_wb_stb & ~ack_ff;
  wire wr = req & i_wb_we & i_wb_sel[0] & mapped;
  wire rd_flags = req & ~i_wb_we & mapped & (idx == REG_FLAGS);
  wire wr_en = wr & (idx == REG_EN);
  wire [7:0] gen_rd = (idx <= 4'h9) ? regs_ff[idx] : RST_OTHER;
  wire [7:0] rd_byte = !mapped ? RST_OTHER :
    (idx == REG_EN) ? en_ff :
    (idx == REG_FLAGS) ? flags_ff :
    (idx == REG_FILT) ? {regs_ff[0][7:3], SILICON_REV} : gen_rd;

  function automatic logic [7:0] rst_val(input int i);
    case (i)
      0: rst_val = RST_FILT;
      1: rst_val = RST_INPUT_VOLTAGE_FLASH_MONITOR;
      2: rst_val = RST_NTC;
      7: rst_val = RST_CFG;
      8: rst_val = RST_FEAT;
      9: rst_val = RST_CUR;
      default: rst_val = RST_OTHER;
    endcase
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (req) begin
        dat_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    for (int i = 0; i < 10; i++) begin
      if (!i_nrst) begin
        regs_ff[i] <= rst_val(i);
      end else if (wr && idx == 4'(i)) begin
        regs_ff[i] <= i_wb_dat[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields
  wire uv_en = regs_ff[REG_INPUT_VOLTAGE_FLASH_MONITOR][INPUT_VOLTAGE_FLASH_MONITOR_UV_EN];
  wire cfg_level = regs_ff[REG_CFG][CFG_LEVEL];
  wire ntc_to_torch = regs_ff[REG_CFG][CFG_NTC_SEL];
  wire [2:0] tout_code = regs_ff[REG_FEAT][2:0];
  wire [3:0] flash_code = regs_ff[REG_CUR][3:0];
  wire [3:0] torch_code = {1'b0, regs_ff[REG_CUR][6:4]};
  wire [1:0] mode = en_ff[1:0];
  wire [31:0] tout_lim = 32'(TOUT_STEP * (32'(tout_code) + 32'h0000_0001));

  ////////////////////////////////////////////////////////////////////////////
  // activation requests
  state_t st_ff;
  state_t nxt_st;
  logic strobe_hold_ff;
  logic ntc_dim_ff;
  logic [3:0] level_ff;
  logic [3:0] nxt_level;
  logic [31:0] step_cnt_ff;
  logic [31:0] tout_cnt_ff;
  logic [31:0] act_cnt_ff;
  logic flash_act_ff;
  logic ntc_on_ff;
  // edge strobe latched until time-out, lock, or the mode leaves flash
  wire strobe_go = ~en_ff[EN_STROBE] |
    (cfg_level ? s2_ff.strobe : strobe_hold_ff);
  wire want_flash = ~lock_ff & (mode == MODE_FLASH) & strobe_go;
  wire want_torch = ~lock_ff & ((mode == MODE_TORCH) |
    (en_ff[EN_TORCH] & s2_ff.torch));
  wire want = want_flash | want_torch;
  wire active = st_ff != ST_IDLE;
  wire tout_evt = active & want_flash & (tout_cnt_ff == tout_lim - 1);
  // level strobe dropped early: flash ends, mode kept only for torch-to-flash
  wire strobe_end = flash_act_ff & ~want_flash & (mode == MODE_FLASH)
    & ~lock_ff;
  wire end_clear = strobe_end & ~en_ff[EN_TORCH];

  ////////////////////////////////////////////////////////////////////////////
  // faults
  wire led_chk = act_cnt_ff >= LED_DLY;
  wire vout_chk = act_cnt_ff >= VOUT_DLY;
  wire led_bad = s2_ff.ovp | s2_ff.led_low;
  wire led_fault = (st_ff == ST_RUN) & want &
    ((led_chk & led_bad) | (vout_chk & s2_ff.vout_low));
  wire uv_fault = s2_ff.input_undervoltage_lockout_trip & uv_en;
  wire tsd_fault = s2_ff.die_hot;
  wire ntc_trip = ntc_on_ff & s2_ff.ntc_below;
  wire ntc_dim = ntc_trip & want_flash & ntc_to_torch;
  wire ntc_fault = ntc_trip & ~ntc_dim;
  // dimmed flash defers the mode clear to its own end
  wire dim_end = ntc_dim_ff & (tout_evt | strobe_end);
  wire fault = uv_fault | tsd_fault | led_fault | ntc_fault | dim_end;
  wire [7:0] evts = {3'h0, ntc_trip, led_fault, tsd_fault, uv_fault,
    tout_evt};

  ////////////////////////////////////////////////////////////////////////////
  // enable register: hardware clears win over host writes
  logic [7:0] nxt_en;
  logic [7:0] lock_mask;
  always_comb begin
    lock_mask = 8'h00;
    lock_mask[EN_TORCH] = 1'b1;
    lock_mask[EN_PRECHG] = 1'b1;
    lock_mask[1:0] = 2'h3;
    nxt_en = en_ff;
    if (wr_en) begin
      nxt_en = lock_ff ? ((en_ff & lock_mask) | (i_wb_dat[7:0] & ~lock_mask))
        : i_wb_dat[7:0];
    end
    if (tout_evt | end_clear) begin
      nxt_en[1:0] = MODE_OFF;
    end
    if (fault | lock_ff) begin
      nxt_en = nxt_en & ~lock_mask;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      en_ff <= RST_EN;
      flags_ff <= RST_FLAGS;
      lock_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      // new events win over the clearing read
      flags_ff <= (flags_ff & ~(rd_flags ? 8'hFF : 8'h00)) | evts;
      lock_ff <= fault | (lock_ff & ~rd_flags);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequencer and current ramp
  wire [3:0] target = (want_flash & ~ntc_dim_ff & ~ntc_dim) ?
    flash_code : torch_code;
  wire step_due = step_cnt_ff >= RAMP_STEP - 1;
  always_comb begin
    nxt_st = st_ff;
    nxt_level = level_ff;
    case (st_ff)
      ST_IDLE: begin
        if (want) begin
          nxt_st = s2_ff.vout_ready ? ST_RUN : ST_PRECHG;
        end
      end
      ST_PRECHG: begin
        if (!want) begin
          nxt_st = ST_IDLE;
        end else if (s2_ff.vout_ready) begin
          nxt_st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!want) begin
          nxt_st = ST_IDLE;
          nxt_level = 4'h0;
        end else if (level_ff > target) begin
          nxt_level = target;
        end else if (step_due && level_ff < target) begin
          nxt_level = level_ff + 4'h1;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_level = 4'h0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_ff <= ST_IDLE;
      level_ff <= 4'h0;
      step_cnt_ff <= 32'h0000_0000;
      tout_cnt_ff <= 32'h0000_0000;
      act_cnt_ff <= 32'h0000_0000;
      flash_act_ff <= 1'b0;
      strobe_hold_ff <= 1'b0;
      ntc_dim_ff <= 1'b0;
      ntc_on_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      level_ff <= nxt_level;
      step_cnt_ff <= (st_ff != ST_RUN || step_due) ? 32'h0000_0000
        : step_cnt_ff + 32'h0000_0001;
      tout_cnt_ff <= (active && want_flash) ? tout_cnt_ff + 32'h0000_0001
        : 32'h0000_0000;
      // saturates once the slower output-node check is armed
      act_cnt_ff <= !active ? 32'h0000_0000 :
        (vout_chk ? act_cnt_ff : act_cnt_ff + 32'h0000_0001);
      flash_act_ff <= active & want_flash;
      // edge strobe must latch before it can raise the flash request
      if (tout_evt || lock_ff || mode != MODE_FLASH) begin
        strobe_hold_ff <= 1'b0;
      end else if (strobe_rise) begin
        strobe_hold_ff <= 1'b1;
      end
      ntc_dim_ff <= (ntc_dim_ff | ntc_dim) & want_flash;
      ntc_on_ff <= en_ff[EN_NTC] & (nxt_st != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_drive <= '0;
    end else begin
      o_drive.converter_on <= nxt_st != ST_IDLE;
      o_drive.precharge <= nxt_st == ST_PRECHG;
      o_drive.led_on <= (nxt_st == ST_RUN) & ~ntc_fault;
      o_drive.flash_scale <= want_flash & ~ntc_dim_ff & ~ntc_dim;
      o_drive.level <= nxt_level;
      o_drive.ntc_on <= en_ff[EN_NTC] & (nxt_st != ST_IDLE);
      o_drive.ntc_thresh <= regs_ff[REG_NTC][2:0];
    end
  end
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = dat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_prechg_done;
    st_ff == ST_PRECHG && want && s2_ff.vout_ready;
  endsequence
  sequence s_ramp_start;
    st_ff == ST_RUN && level_ff == 4'h0;
  endsequence

  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");
  a_read_clears: assert property (rd_flags && evts == 8'h00 |=>
    flags_ff == 8'h00 && !lock_ff)
    else $error("flags read did not clear");
  a_uv_lockout: assert property (uv_fault |=>
    flags_ff[FL_INPUT_UNDERVOLTAGE_LOCKOUT] && lock_ff && en_ff[1:0] == MODE_OFF)
    else $error("undervoltage not handled");
  a_uv_enable: assert property ($rose(flags_ff[FL_INPUT_UNDERVOLTAGE_LOCKOUT]) |->
    $past(uv_en))
    else $error("undervoltage flag while disabled");
  a_tsd_standby: assert property (tsd_fault |=>
    flags_ff[FL_TSD] && lock_ff ##1 st_ff == ST_IDLE)
    else $error("die overheat not handled");
  a_lock_holds: assert property (lock_ff && !rd_flags |=>
    lock_ff && en_ff[1:0] == MODE_OFF && !en_ff[EN_TORCH])
    else $error("lock released without read");
  a_led_blank: assert property (act_cnt_ff < LED_DLY |->
    !led_fault)
    else $error("led fault before blanking");
  a_tout_clear: assert property (tout_evt |=>
    en_ff[1:0] == MODE_OFF && flags_ff[FL_TOUT])
    else $error("time-out did not clear mode");
  a_prechg_ramp: assert property (s_prechg_done |=> s_ramp_start)
    else $error("precharge did not hand over to ramp");
  a_ramp_step: assert property (st_ff == ST_RUN && $past(st_ff) == ST_RUN
    && level_ff > $past(level_ff) |-> level_ff == $past(level_ff) + 4'h1)
    else $error("ramp skipped a step");
  a_ntc_power: assert property (!active |=> !o_drive.ntc_on || active)
    else $error("thermistor detector on while idle");
endmodule
`default_nettype wire

// ### flash_ctl_pkg.sv
// Functional notes
// - thermistor below threshold interrupts LED current
// - thermistor trip in flash: torch or off
// - thermistor detector powered only during events
// - thermistor event clears operating mode bits
// - input undervoltage: shutdown and set flag
// - undervoltage lockout held until flags read
// - monitor enable zero disables undervoltage lockout
// - undervoltage event clears operating mode bits
// - die overheat: stop, flag, clear, standby
// - restart after flags read; still hot refaults
// - led or output short sets fault flag
// - overvoltage in flash or torch: open fault
// - led pin low in flash/torch: short
// - led check after 256us, output 2.048ms
// - led flag cleared by read; clears mode
// - precharge output, then step current to target
// - sixteen flash current levels via control register
// - flash from register or strobe, full ramp
// - register flash: time-out clears mode bits
// - strobe flash clears mode; host rewrites
// - torch-to-flash level: clear only on time-out
// - any fault locks enable bits until read
// - eight time-outs, 100 to 800 ms
`default_nettype none
package flash_ctl_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int LED_DLY_US = 256;
  localparam int LED_DLY_CYC = LED_DLY_US * CYC_PER_US;
  localparam int VOUT_DLY_US = 2048;
  localparam int VOUT_DLY_CYC = VOUT_DLY_US * CYC_PER_US;
  localparam int TOUT_STEP_MS = 100;
  localparam int TOUT_STEP_CYC = TOUT_STEP_MS * 1000 * CYC_PER_US;
  localparam int RAMP_STEP_US = 32;
  localparam int RAMP_STEP_CYC = RAMP_STEP_US * CYC_PER_US;
  // register indices; byte address is four times the index
  localparam logic [3:0] REG_FILT = 4'h0;
  localparam logic [3:0] REG_INPUT_VOLTAGE_FLASH_MONITOR = 4'h1;
  localparam logic [3:0] REG_NTC = 4'h2;
  localparam logic [3:0] REG_CFG = 4'h7;
  localparam logic [3:0] REG_FEAT = 4'h8;
  localparam logic [3:0] REG_CUR = 4'h9;
  localparam logic [3:0] REG_EN = 4'hA;
  localparam logic [3:0] REG_FLAGS = 4'hB;
  localparam logic [7:0] RST_FILT = 8'h04;
  localparam logic [7:0] RST_INPUT_VOLTAGE_FLASH_MONITOR = 8'h80;
  localparam logic [7:0] RST_NTC = 8'h12;
  localparam logic [7:0] RST_CFG = 8'h78;
  localparam logic [7:0] RST_FEAT = 8'hD2;
  localparam logic [7:0] RST_CUR = 8'h0F;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_OTHER = 8'h00;
  // field positions
  localparam int INPUT_VOLTAGE_FLASH_MONITOR_UV_EN = 7;
  localparam int CFG_LEVEL = 7;
  localparam int CFG_NTC_SEL = 3;
  localparam int EN_NTC = 6;
  localparam int EN_STROBE = 5;
  localparam int EN_TORCH = 4;
  localparam int EN_PRECHG = 2;
  localparam int FL_TOUT = 0;
  localparam int FL_INPUT_UNDERVOLTAGE_LOCKOUT = 1;
  localparam int FL_TSD = 2;
  localparam int FL_LED = 3;
  localparam int FL_NTC = 4;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TORCH = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRECHG = 2'b01,
    ST_RUN = 2'b10
  } state_t;
  typedef struct packed {
    logic strobe;
    logic torch;
    logic input_undervoltage_lockout_trip;
    logic die_hot;
    logic ntc_below;
    logic ovp;
    logic led_low;
    logic vout_low;
    logic vout_ready;
  } sense_t;
  typedef struct packed {
    logic converter_on;
    logic precharge;
    logic led_on;
    logic flash_scale;
    logic [3:0] level;
    logic ntc_on;
    logic [2:0] ntc_thresh;
  } drive_t;
endpackage
`default_nettype wire

// ### flash_afe_model.sv
`default_nettype none
module flash_afe_model
  import flash_ctl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire drive_t i_drive,
  output logic o_vout_ready
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////
  // output cap charges a few cycles after the converter starts
  // slow on purpose so the precharge phase is visible at the ports
  always @(posedge i_clock) begin
    if (!i_nrst || !(i_drive.converter_on || i_drive.precharge)) begin
      cnt <= 0;
      o_vout_ready <= 1'b0;
    end else begin
      if (cnt < 12) cnt <= cnt + 1;
      o_vout_ready <= (cnt >= 11);
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctl_pkg::*;
  logic i_clock, i_nrst, cyc, stb, we, vr, pl_on, lk;
  logic [7:0] adr, q, fc;
  logic [31:0] dat, rdat;
  logic ack;
  logic [3:0] pl;
  sense_t sn, sense_w;
  drive_t drv;
  logic [7:0] mdl [64];
  int failures, total_checks, seed, n, d;
  assign sense_w = sense_t'({sn[8:1], vr});
  flash_ctl #(.LED_DLY(16), .VOUT_DLY(64), .TOUT_STEP(200), .RAMP_STEP(4))
    u_flash_ctl (.i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1),
    .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sense(sense_w),
    .o_drive(drv));
  flash_afe_model u_flash_afe_model (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_drive(drv), .o_vout_ready(vr));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 0;
    forever #20 i_clock = ~i_clock;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    test_done();
  end
  // ramp must climb one step at a time, never with precharge active
  always @(posedge i_clock) begin
    if (i_nrst) begin
      `CHK("ramp", 1'b1, !(drv.led_on && pl_on && drv.level > pl + 1))
      `CHK("prechg", 1'b1, !(drv.precharge && drv.led_on))
    end
    pl <= drv.level;
    pl_on <= drv.led_on;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] v);
    @(posedge i_clock);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; dat <= {24'h0, v};
    n = 0;
    do begin @(posedge i_clock); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = rdat[7:0];
    cyc <= 0; stb <= 0;
  endtask
  // model of the register file, with lock masking on the enable byte
  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    bus(1, i, v);
    if (i == 0) mdl[0] = {v[7:3], 3'h1};
    else if (i == 10 && lk) mdl[10] = (mdl[10] & 8'h17) | (v & 8'hE8);
    else if (i < 11) mdl[i] = v;
  endtask
  task automatic rd(input logic [5:0] i);
    bus(0, i, 8'h00);
    `CHK("reg", mdl[i], q)
    if (i == 11) begin mdl[11] = 0; lk = 0; end
  endtask
  task automatic cyc_w(input int c);
    repeat (c) @(posedge i_clock);
  endtask
  task automatic wled(input logic v);
    n = 0;
    while (drv.led_on !== v && n < 900) begin @(posedge i_clock); n++; end
    `CHK("led_on", v, drv.led_on)
  endtask
  task automatic fault(input logic [7:0] fl);
    cyc_w(100);
    mdl[11] = fl; mdl[10] = mdl[10] & 8'hE8; lk = 1;
    `CHK("led_off", 1'b0, drv.led_on)
    rd(10);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; sn = '0; lk = 0;
    seed = 60; failures = 0; total_checks = 0; i_nrst = 0;
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[0] = {RST_FILT[7:3], 3'h1}; mdl[1] = RST_INPUT_VOLTAGE_FLASH_MONITOR; mdl[2] = RST_NTC;
    mdl[7] = RST_CFG; mdl[8] = RST_FEAT; mdl[9] = RST_CUR;
    repeat (20) @(posedge i_clock);
    i_nrst <= 1;
    for (int k = 0; k < 12; k++) rd(k[5:0]);
    wr(11, 8'hFF); wr(6'h0C, 8'h5A); wr(6'h10, 8'hA5);
    rd(11); rd(6'h0C); rd(6'h10);
    // register flash, two time-out codes, random target level
    for (int tc = 0; tc < 2; tc++) begin
      fc = 8'($random(seed)) & 8'h0F | 8'h01;
      wr(8, 8'hD0 | tc[7:0]); wr(9, fc); wr(10, 8'h03);
      wled(1);
      n = 0;
      while (drv.level !== fc[3:0] && n < 100) begin cyc_w(1); n++; end
      `CHK("flvl", {1'b1, fc[3:0]}, {drv.flash_scale, drv.level})
      d = 0;
      while (drv.led_on === 1'b1 && d < 900) begin cyc_w(1); d++; end
      `CHK("tout", 1'b1, d > (tc+1)*200-70 && d < (tc+1)*200+10)
      cyc_w(4); mdl[10] = 0; mdl[11] = 8'h01;
      rd(10); rd(11);
    end
    // edge strobe flash, then torch-to-flash with a short level strobe
    wr(10, 8'h23); sn.strobe <= 1; cyc_w(3); sn.strobe <= 0; wled(1);
    wled(0); cyc_w(4); mdl[10] = 8'h20; mdl[11] = 8'h01;
    rd(10); rd(11);
    wr(7, 8'hF8); wr(10, 8'h33); sn.strobe <= 1; wled(1);
    cyc_w(30); sn.strobe <= 0; cyc_w(10);
    rd(10);
    wr(10, 8'h00); wr(7, 8'h78);
    // undervoltage: trip, locked writes, read releases, then disable
    wr(10, 8'h02); wled(1); sn.input_undervoltage_lockout_trip <= 1; cyc_w(6); sn.input_undervoltage_lockout_trip <= 0;
    fault(8'h02);
    wr(10, 8'h02); rd(10);
    rd(11); wr(10, 8'h02); rd(10); wled(1);
    wr(10, 8'h00); wr(1, 8'h00); sn.input_undervoltage_lockout_trip <= 1; cyc_w(8);
    rd(11); sn.input_undervoltage_lockout_trip <= 0; wr(1, 8'h80);
    // die overheat: read while hot sets the flag again
    wr(10, 8'h02); wled(1); sn.die_hot <= 1; fault(8'h04);
    `CHK("conv", 1'b0, drv.converter_on)
    rd(11); sn.die_hot <= 0; cyc_w(6); mdl[11] = 8'h04;
    rd(11); rd(11);
    // led open, led short, output short
    for (int k = 0; k < 3; k++) begin
      wr(10, 8'h02); wled(1);
      sn.ovp <= (k == 0); sn.led_low <= (k == 1); sn.vout_low <= (k == 2);
      fault(8'h08);
      sn.ovp <= 0; sn.led_low <= 0; sn.vout_low <= 0;
      rd(11);
    end
    // thermistor: shutdown response, then drop to torch during flash
    fc = 8'($random(seed)) & 8'h07;
    wr(2, 8'h10 | fc); wr(7, 8'h70); wr(10, 8'h42); wled(1);
    `CHK("nthr", {1'b1, fc[2:0]}, {drv.ntc_on, drv.ntc_thresh})
    sn.ntc_below <= 1; fault(8'h10);
    sn.ntc_below <= 0; rd(11); cyc_w(4);
    `CHK("ntcoff", 1'b0, drv.ntc_on)
    wr(7, 8'h78); wr(9, 8'h3F); wr(10, 8'h43); wled(1); cyc_w(80);
    sn.ntc_below <= 1; cyc_w(8);
    `CHK("ntcdrop", 5'h03, {drv.flash_scale, drv.level})
    sn.ntc_below <= 0; wled(0); cyc_w(4); mdl[11] = 8'h11; rd(11);
    test_done();
  end
endmodule
`undef CHK
`default_nettype wire
